// ### rtl/flash_cfg_pkg.sv
package flash_cfg_pkg;

	// command codes seen on the link data lines
	localparam logic [15:0] CMD_CFG_SETUP = 16'h0060;
	localparam logic [15:0] CMD_CONF_READ_CFG = 16'h0003;
	localparam logic [15:0] CMD_CONF_DRIVE_CFG = 16'h0004;
	localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
	localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
	localparam logic [15:0] CMD_READ_ID = 16'h0090;
	localparam logic [15:0] CMD_READ_CFI = 16'h0098;
	localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;

	// burst_read_config field positions
	localparam int READ_MODE_BIT = 15;
	localparam int LAT_MSB = 14;
	localparam int LAT_LSB = 11;
	localparam int WAIT_POL_BIT = 10;
	localparam int WAIT_EARLY_BIT = 8;
	localparam int BUS_IF_BIT = 4;
	localparam int BURST_MSB = 2;
	localparam int BURST_LSB = 0;
	localparam logic [2:0] BURST_WRAP8 = 3'h2;
	localparam logic [2:0] BURST_WRAP16 = 3'h3;
	localparam logic [2:0] BURST_LINEAR = 3'h7;
	localparam logic [3:0] LAT_MIN = 4'h3;
	localparam logic [3:0] LAT_MAX = 4'he;
	localparam logic [15:0] READ_CFG_RSVD_MASK = 16'h02e8;
	localparam logic [15:0] READ_CFG_RESET = 16'h8000;

	// output_drive_config
	localparam int DRIVE_MSB = 2;
	localparam logic [15:0] DRIVE_FIELD_MASK = 16'h0007;
	localparam logic [2:0] DRIVE_RESET = 3'h4;

	// identification-read offsets
	localparam logic [7:0] ID_OFS_MAKER = 8'h00;
	localparam logic [7:0] ID_OFS_PART = 8'h01;
	localparam logic [7:0] ID_OFS_READ_CFG = 8'h05;
	localparam logic [7:0] ID_OFS_DRIVE_CFG = 8'h06;

	// status word and fixed read values
	localparam logic [15:0] STATUS_READY = 16'h0080;
	localparam logic [15:0] STATUS_SEQ_ERR = 16'h0030;
	localparam logic [15:0] ARRAY_ERASED = 16'hffff;
	localparam logic [15:0] CFI_BLANK = 16'h0000;
	localparam logic WAIT_PIN_RESET = 1'b1;

	typedef enum logic [1:0] {
		MODE_ARRAY,
		MODE_STATUS,
		MODE_ID,
		MODE_CFI
	} read_mode_t;

	// controller register map (apb byte offsets)
	localparam logic [7:0] REG_VALUE = 8'h00;
	localparam logic [7:0] REG_DATA = 8'h04;
	localparam logic [7:0] REG_GO = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_SHIFT = 8'h10;
	localparam logic [1:0] OP_LOAD_READ_CFG = 2'h0;
	localparam logic [1:0] OP_LOAD_DRIVE_CFG = 2'h1;
	localparam logic [1:0] OP_SINGLE_WRITE = 2'h2;
	localparam logic [1:0] OP_SINGLE_READ = 2'h3;

endpackage

// ### rtl/flash_link_if.sv
`timescale 1ns/100ps
interface flash_link_if;
	logic we;
	logic re;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic rvalid;
	logic burst_wait;

	modport ctrl (
		output we,
		output re,
		output addr,
		output wdata,
		input rdata,
		input rvalid,
		input burst_wait
	);

	modport mem (
		input we,
		input re,
		input addr,
		input wdata,
		output rdata,
		output rvalid,
		output burst_wait
	);
endinterface

// ### rtl/flash_config_device.sv
`timescale 1ns/100ps
module flash_config_device #(
	parameter logic [15:0] MAKER_CODE = 16'h005a, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'h0123 // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	flash_link_if.mem link,
	output logic sync_mode,
	output logic [3:0] latency_code,
	output logic wait_high,
	output logic wait_early,
	output logic split_addr_muxed_bus,
	output logic [2:0] burst_length,
	output logic [2:0] drive_strength,
	output logic cmd_seq_error,
	output flash_cfg_pkg::read_mode_t read_mode
);

	typedef struct packed {
		logic [15:0] read_cfg;
		logic [2:0] drive;
		flash_cfg_pkg::read_mode_t mode;
		logic setup_seen;
		logic seq_err;
		logic rd_busy;
		logic [3:0] rd_cnt;
		logic [15:0] rd_addr;
		logic [15:0] rdata;
		logic rvalid;
		logic wait_pin;
	} dev_state_t;

	localparam dev_state_t DEV_RESET = '{
		read_cfg: flash_cfg_pkg::READ_CFG_RESET,
		drive: flash_cfg_pkg::DRIVE_RESET,
		mode: flash_cfg_pkg::MODE_ARRAY,
		setup_seen: 1'b0,
		seq_err: 1'b0,
		rd_busy: 1'b0,
		rd_cnt: 4'h0,
		rd_addr: 16'h0000,
		rdata: 16'h0000,
		rvalid: 1'b0,
		wait_pin: flash_cfg_pkg::WAIT_PIN_RESET
	};

	dev_state_t s_reg;
	dev_state_t s_next;
	logic [3:0] lat_eff;
	logic wait_active;

	// word returned for a read in the given mode and address
	function automatic logic [15:0] read_word(
		input flash_cfg_pkg::read_mode_t m,
		input logic [15:0] a,
		input dev_state_t st
	);
		logic [15:0] w;
		w = 16'h0000;
		unique case (m)
			flash_cfg_pkg::MODE_ARRAY: begin
				// no array behind this block: reads look erased
				w = flash_cfg_pkg::ARRAY_ERASED;
			end
			flash_cfg_pkg::MODE_STATUS: begin
				w = flash_cfg_pkg::STATUS_READY;
				if (st.seq_err) begin
					w = w | flash_cfg_pkg::STATUS_SEQ_ERR;
				end
			end
			flash_cfg_pkg::MODE_ID: begin
				// partition base is ignored, only the offset counts
				if (a[7:0] == flash_cfg_pkg::ID_OFS_MAKER) begin
					w = MAKER_CODE;
				end else if (a[7:0] == flash_cfg_pkg::ID_OFS_PART) begin
					w = PART_CODE;
				end else if (a[7:0] == flash_cfg_pkg::ID_OFS_READ_CFG) begin
					w = st.read_cfg;
				end else if (a[7:0] == flash_cfg_pkg::ID_OFS_DRIVE_CFG) begin
					w = {13'h0000, st.drive};
				end
			end
			flash_cfg_pkg::MODE_CFI: begin
				w = flash_cfg_pkg::CFI_BLANK;
			end
		endcase
		return w;
	endfunction

	// reserved latency codes below the floor run at the floor
	always_comb begin
		lat_eff = s_reg.read_cfg[flash_cfg_pkg::LAT_MSB:flash_cfg_pkg::LAT_LSB];
		if (lat_eff < flash_cfg_pkg::LAT_MIN) begin
			lat_eff = flash_cfg_pkg::LAT_MIN;
		end
	end

	// command decode, read timing and wait pin
	always_comb begin
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		wait_active = 1'b0;

		if (link.we) begin
			if (s_reg.setup_seen) begin
				s_next.setup_seen = 1'b0;
				if (link.wdata == flash_cfg_pkg::CMD_CONF_READ_CFG) begin
					s_next.read_cfg = link.addr;
					s_next.mode = flash_cfg_pkg::MODE_ARRAY;
				end else if (link.wdata == flash_cfg_pkg::CMD_CONF_DRIVE_CFG) begin
					// no program-supply check on this path
					s_next.drive =
						link.addr[flash_cfg_pkg::DRIVE_MSB:0];
					s_next.mode = flash_cfg_pkg::MODE_ARRAY;
				end else begin
					// both registers keep their values
					s_next.seq_err = 1'b1;
					s_next.mode = flash_cfg_pkg::MODE_STATUS;
				end
			end else begin
				unique case (link.wdata)
					flash_cfg_pkg::CMD_CFG_SETUP: begin
						s_next.setup_seen = 1'b1;
						s_next.mode = flash_cfg_pkg::MODE_STATUS;
					end
					flash_cfg_pkg::CMD_READ_ARRAY: begin
						s_next.mode = flash_cfg_pkg::MODE_ARRAY;
					end
					flash_cfg_pkg::CMD_READ_STATUS: begin
						s_next.mode = flash_cfg_pkg::MODE_STATUS;
					end
					flash_cfg_pkg::CMD_READ_ID: begin
						s_next.mode = flash_cfg_pkg::MODE_ID;
					end
					flash_cfg_pkg::CMD_READ_CFI: begin
						s_next.mode = flash_cfg_pkg::MODE_CFI;
					end
					flash_cfg_pkg::CMD_CLEAR_STATUS: begin
						s_next.seq_err = 1'b0;
						s_next.mode = flash_cfg_pkg::MODE_STATUS;
					end
					default: begin
						// other command codes belong to array machinery
						s_next.mode = s_reg.mode;
					end
				endcase
			end
		end

		if (link.re && !s_reg.rd_busy) begin
			s_next.rd_addr = link.addr;
			if (s_reg.read_cfg[flash_cfg_pkg::READ_MODE_BIT]) begin
				// async: data next cycle, other fields ignored
				s_next.rdata = read_word(s_reg.mode, link.addr, s_reg);
				s_next.rvalid = 1'b1;
			end else begin
				s_next.rd_busy = 1'b1;
				s_next.rd_cnt = lat_eff;
			end
		end else if (s_reg.rd_busy) begin
			s_next.rd_cnt = s_reg.rd_cnt - 4'h1;
			if (s_reg.rd_cnt == 4'h1) begin
				s_next.rdata = read_word(s_reg.mode, s_reg.rd_addr, s_reg);
				s_next.rvalid = 1'b1;
				s_next.rd_busy = 1'b0;
			end
		end

		// wait is active while a sync read is pending, released one cycle before the word when the early bit is set
		wait_active = s_next.rd_busy;
		if (s_next.read_cfg[flash_cfg_pkg::WAIT_EARLY_BIT] &&
				s_next.rd_cnt == 4'h1) begin
			wait_active = 1'b0;
		end
		// polarity bit decides which level means "wait"
		s_next.wait_pin = wait_active ~^
			s_next.read_cfg[flash_cfg_pkg::WAIT_POL_BIT];
	end

	// state register; the pin only moves on clock edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= DEV_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// link outputs
	assign link.rdata = s_reg.rdata;
	assign link.rvalid = s_reg.rvalid;
	assign link.burst_wait = s_reg.wait_pin;

	// configuration fields seen by the rest of the chip
	assign sync_mode = ~s_reg.read_cfg[flash_cfg_pkg::READ_MODE_BIT];
	assign latency_code =
		s_reg.read_cfg[flash_cfg_pkg::LAT_MSB:flash_cfg_pkg::LAT_LSB];
	assign wait_high = s_reg.read_cfg[flash_cfg_pkg::WAIT_POL_BIT];
	assign wait_early = s_reg.read_cfg[flash_cfg_pkg::WAIT_EARLY_BIT];
	assign split_addr_muxed_bus =
		s_reg.read_cfg[flash_cfg_pkg::BUS_IF_BIT];
	assign burst_length =
		s_reg.read_cfg[flash_cfg_pkg::BURST_MSB:flash_cfg_pkg::BURST_LSB];
	assign drive_strength = s_reg.drive;
	assign cmd_seq_error = s_reg.seq_err;
	assign read_mode = s_reg.mode;

endmodule

// ### rtl/flash_config_host.sv
`timescale 1ns/100ps
module flash_config_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	flash_link_if.ctrl link
);

	typedef enum logic [1:0] {
		H_IDLE,
		H_CONFIRM,
		H_RDWAIT
	} host_phase_t;

	typedef struct packed {
		logic [15:0] value;
		logic [15:0] data;
		logic [1:0] shift;
		logic [15:0] rdback;
		logic [1:0] op;
		host_phase_t phase;
		logic we;
		logic re;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} host_state_t;

	host_state_t s_reg;
	host_state_t s_next;
	logic [15:0] cfg_val;
	logic busy;

	// link sequencer first, then the apb slave, which may launch
	always_comb begin
		s_next = s_reg;
		s_next.we = 1'b0;
		s_next.re = 1'b0;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		busy = (s_reg.phase != H_IDLE);
		cfg_val = s_reg.value;
		if (pwdata[1:0] == flash_cfg_pkg::OP_LOAD_READ_CFG) begin
			cfg_val = s_reg.value & ~flash_cfg_pkg::READ_CFG_RSVD_MASK;
		end else if (pwdata[1:0] == flash_cfg_pkg::OP_LOAD_DRIVE_CFG) begin
			cfg_val = s_reg.value & flash_cfg_pkg::DRIVE_FIELD_MASK;
		end

		unique case (s_reg.phase)
			H_IDLE: begin
				s_next.phase = H_IDLE;
			end
			H_CONFIRM: begin
				// confirm follows setup back to back, same address
				s_next.we = 1'b1;
				s_next.wdata = (s_reg.op == flash_cfg_pkg::OP_LOAD_READ_CFG) ?
					flash_cfg_pkg::CMD_CONF_READ_CFG :
					flash_cfg_pkg::CMD_CONF_DRIVE_CFG;
				s_next.phase = H_IDLE;
			end
			H_RDWAIT: begin
				if (link.rvalid) begin
					s_next.rdback = link.rdata;
					s_next.phase = H_IDLE;
				end
			end
		endcase

		// one wait state: pready rises in the second access cycle
		if (psel && penable && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			if (pwrite) begin
				if (paddr == flash_cfg_pkg::REG_VALUE) begin
					s_next.value = pwdata[15:0];
				end else if (paddr == flash_cfg_pkg::REG_DATA) begin
					s_next.data = pwdata[15:0];
				end else if (paddr == flash_cfg_pkg::REG_SHIFT) begin
					s_next.shift = pwdata[1:0];
				end else if (paddr == flash_cfg_pkg::REG_GO) begin
					if (busy) begin
						// no read slips in while a load is under way
						s_next.pslverr = 1'b1;
					end else begin
						s_next.op = pwdata[1:0];
						s_next.addr = 16'(cfg_val << s_reg.shift);
						if (pwdata[1:0] == flash_cfg_pkg::OP_SINGLE_READ) begin
							s_next.re = 1'b1;
							s_next.phase = H_RDWAIT;
						end else if (pwdata[1:0] == flash_cfg_pkg::OP_SINGLE_WRITE) begin
							s_next.we = 1'b1;
							s_next.wdata = s_reg.data;
						end else begin
							s_next.we = 1'b1;
							s_next.wdata = flash_cfg_pkg::CMD_CFG_SETUP;
							s_next.phase = H_CONFIRM;
						end
					end
				end else if (paddr != flash_cfg_pkg::REG_STATUS) begin
					s_next.pslverr = 1'b1;
				end
			end else begin
				if (paddr == flash_cfg_pkg::REG_VALUE) begin
					s_next.prdata = {16'h0000, s_reg.value};
				end else if (paddr == flash_cfg_pkg::REG_DATA) begin
					s_next.prdata = {16'h0000, s_reg.data};
				end else if (paddr == flash_cfg_pkg::REG_SHIFT) begin
					s_next.prdata = {30'h0000_0000, s_reg.shift};
				end else if (paddr == flash_cfg_pkg::REG_STATUS) begin
					s_next.prdata = {s_reg.rdback, 15'h0000, busy};
				end else if (paddr != flash_cfg_pkg::REG_GO) begin
					s_next.pslverr = 1'b1;
				end
			end
		end
	end

	// all state in one register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pready = s_reg.pready;
	assign prdata = s_reg.prdata;
	assign pslverr = s_reg.pslverr;
	assign link.we = s_reg.we;
	assign link.re = s_reg.re;
	assign link.addr = s_reg.addr;
	assign link.wdata = s_reg.wdata;

endmodule

// ### sim/flash_cfg_assertions.sv
`timescale 1ns/100ps
module flash_cfg_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic re,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic rvalid,
	input wire logic burst_wait
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic setup_reg, sync_reg, pol_reg, early_reg, pend_reg, load;
	logic [3:0] lat_reg;
	logic [4:0] cnt_reg, eff, rel;
	// shadow of the timing fields, rebuilt from loads seen on the wires
	assign load = we && setup_reg &&
		wdata == flash_cfg_pkg::CMD_CONF_READ_CFG;
	assign eff = (lat_reg < 4'h3) ? 5'h03 : {1'b0, lat_reg};
	assign rel = eff + 5'h01 - {4'h0, early_reg};
	// only sync reads are timed; async ones have a fixed one-cycle answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup_reg <= 1'b0;
			sync_reg <= 1'b0;
			pol_reg <= 1'b0;
			early_reg <= 1'b0;
			lat_reg <= 4'h0;
			pend_reg <= 1'b0;
			cnt_reg <= 5'h00;
		end else begin
			if (we) begin
				setup_reg <= wdata == flash_cfg_pkg::CMD_CFG_SETUP;
			end
			if (load) begin
				sync_reg <= !addr[15];
				lat_reg <= addr[14:11];
				pol_reg <= addr[10];
				early_reg <= addr[8];
			end
			if (re && sync_reg && !pend_reg) begin
				pend_reg <= 1'b1;
				cnt_reg <= 5'h01;
			end else if (pend_reg) begin
				cnt_reg <= cnt_reg + 5'h01;
				if (rvalid) begin
					pend_reg <= 1'b0;
				end
			end
		end
	end
	confirm_addr_a: assert property (
		(we && wdata == 16'h0060) ##1 we |-> $stable(addr))
		else $error("confirm address differs");
	no_fetch_a: assert property (
		we && wdata == 16'h0060 |-> !re ##1 !re)
		else $error("read during load");
	rsvd_zero_a: assert property (
		load |-> (addr & flash_cfg_pkg::READ_CFG_RSVD_MASK) == 16'h0000)
		else $error("reserved bits set");
	async_answer_a: assert property (
		re && !sync_reg |=> rvalid)
		else $error("async answer late");
	sync_latency_a: assert property (
		pend_reg && rvalid |-> cnt_reg == eff + 5'h01)
		else $error("sync answer early");
	sync_deliver_a: assert property (
		pend_reg && cnt_reg == eff + 5'h01 |-> rvalid)
		else $error("sync answer missing");
	wait_active_a: assert property (
		pend_reg && cnt_reg < rel |-> burst_wait == pol_reg)
		else $error("wait not active");
	wait_release_a: assert property (
		pend_reg && cnt_reg >= rel |-> burst_wait == !pol_reg)
		else $error("wait not released");
	wait_idle_a: assert property (
		!pend_reg && !$past(we) |-> burst_wait == !pol_reg)
		else $error("wait active when idle");
	cover property (pend_reg && rvalid);
	cover property (load && !addr[15]);
	cover property (we && setup_reg && wdata == 16'h0004);
	cover property (we && setup_reg && wdata == 16'h00d0);
endmodule

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, err, sync_mode, wait_high, wait_early;
	logic split_addr_muxed_bus, cmd_seq_error;
	logic [3:0] latency_code;
	logic [2:0] burst_length, drive_strength;
	flash_cfg_pkg::read_mode_t read_mode;
	int n_fail = 0, checks_done = 0;
	flash_link_if link ();
	always #4 pclk = ~pclk;
	flash_config_host flash_config_host_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.link(link));
	flash_config_device flash_config_device_inst (.pclk(pclk),
		.presetn(presetn), .link(link), .sync_mode(sync_mode),
		.latency_code(latency_code), .wait_high(wait_high),
		.wait_early(wait_early), .split_addr_muxed_bus(split_addr_muxed_bus),
		.burst_length(burst_length), .drive_strength(drive_strength),
		.cmd_seq_error(cmd_seq_error), .read_mode(read_mode));
	flash_cfg_assertions flash_cfg_assertions_inst (.pclk(pclk),
		.presetn(presetn), .we(link.we), .re(link.re), .addr(link.addr),
		.wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
		.burst_wait(link.burst_wait));
	task automatic finish_test();
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// launch one controller op and poll busy; returns the last link word
	task automatic go(logic [1:0] op, logic [15:0] v, logic [15:0] d,
		output logic [15:0] q);
		logic [31:0] s;
		apb(1'b1, flash_cfg_pkg::REG_VALUE, {16'h0, v}, s);
		apb(1'b1, flash_cfg_pkg::REG_DATA, {16'h0, d}, s);
		apb(1'b1, flash_cfg_pkg::REG_GO, {30'h0, op}, s);
		s = 32'h1;
		while (s[0] !== 1'b0) apb(1'b0, flash_cfg_pkg::REG_STATUS, 32'h0, s);
		q = s[31:16];
		@(posedge pclk);
	endtask
	task automatic cmd(logic [15:0] c);
		logic [15:0] q;
		go(flash_cfg_pkg::OP_SINGLE_WRITE, 16'h0, c, q);
	endtask
	task automatic rd(logic [15:0] a, output logic [15:0] q);
		go(flash_cfg_pkg::OP_SINGLE_READ, a, 16'h0, q);
	endtask
	task automatic defaults();
		chk("sync", 16'h0000, 16'(sync_mode));
		chk("drive", 16'h0004, 16'(drive_strength));
		chk("mode", 16'(flash_cfg_pkg::MODE_ARRAY), 16'(read_mode));
		chk("seq_err", 16'h0000, 16'(cmd_seq_error));
	endtask
	function automatic logic [15:0] rcfg(logic m, logic [3:0] l, logic p,
		logic e, logic b, logic [2:0] bl);
		return {m, l, p, 1'b0, e, 3'b000, b, 1'b0, bl};
	endfunction
	initial begin
		logic [15:0] q, v, e;
		logic [31:0] r;
		logic [2:0] bls [3];
		bls = '{flash_cfg_pkg::BURST_WRAP8, flash_cfg_pkg::BURST_WRAP16,
			flash_cfg_pkg::BURST_LINEAR};
		void'($urandom(32'h54ebf181));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		defaults();
		cmd(flash_cfg_pkg::CMD_READ_ID);
		rd(16'h0005, q);
		chk("rcfg_id", 16'h8000, q);
		rd(16'h0006, q);
		chk("dcfg_id", 16'h0004, q);
		// drive codes 1 to 6; stray upper bits must be dropped by the host
		for (int c = 1; c < 7; c++) begin
			v = (16'($urandom) & 16'hfff8) | 16'(c);
			go(flash_cfg_pkg::OP_LOAD_DRIVE_CFG, v, 16'h0, q);
			chk("drive", 16'(c), 16'(drive_strength));
			chk("mode", 16'(flash_cfg_pkg::MODE_ARRAY), 16'(read_mode));
			cmd(flash_cfg_pkg::CMD_READ_ID);
			rd(16'h0006, q);
			chk("dcfg_id", 16'(c), q);
		end
		// corner latencies first, then random fields; a read follows each
		for (int i = 0; i < 8; i++) begin
			e = rcfg(1'($urandom), 4'(3 + $urandom % 12), 1'($urandom),
				1'($urandom), 1'($urandom), bls[$urandom % 3]);
			if (i == 0) e = rcfg(1'b1, 4'h3, 1'b1, 1'b1, 1'b0, bls[0]);
			if (i == 1) e = rcfg(1'b0, 4'he, 1'b0, 1'b0, 1'b1, bls[2]);
			if (i == 2) e = rcfg(1'b0, 4'hc, 1'b1, 1'b1, 1'b0, bls[1]);
			// a 125 MHz burst clock needs latency code 12 or more
			if (!e[15] && e[14:11] < 4'hc) e[14:11] = 4'hc;
			v = e | (16'($urandom) & flash_cfg_pkg::READ_CFG_RSVD_MASK);
			go(flash_cfg_pkg::OP_LOAD_READ_CFG, v, 16'h0, q);
			chk("sync", 16'(!e[15]), 16'(sync_mode));
			chk("lat", 16'(e[14:11]), 16'(latency_code));
			chk("pol", 16'(e[10]), 16'(wait_high));
			chk("early", 16'(e[8]), 16'(wait_early));
			chk("bus", 16'(e[4]), 16'(split_addr_muxed_bus));
			chk("burst", 16'(e[2:0]), 16'(burst_length));
			chk("mode", 16'(flash_cfg_pkg::MODE_ARRAY), 16'(read_mode));
			cmd(flash_cfg_pkg::CMD_READ_ID);
			rd(16'h0005, q);
			chk("rcfg_id", e, q);
			cmd(flash_cfg_pkg::CMD_READ_ARRAY);
			rd(16'($urandom), q);
			chk("array", flash_cfg_pkg::ARRAY_ERASED, q);
			// a second order while a slow read is pending is refused
			if (!e[15]) begin
				apb(1'b1, flash_cfg_pkg::REG_GO,
					{30'h0, flash_cfg_pkg::OP_SINGLE_READ}, r);
				apb(1'b1, flash_cfg_pkg::REG_GO,
					{30'h0, flash_cfg_pkg::OP_SINGLE_WRITE}, r);
				chk("go_busy_err", 16'h0001, 16'(err));
				r = 32'h1;
				while (r[0] !== 1'b0) begin
					apb(1'b0, flash_cfg_pkg::REG_STATUS, 32'h0, r);
				end
				chk("busy_read", flash_cfg_pkg::ARRAY_ERASED, r[31:16]);
			end
		end
		// setup then an unknown confirm: nothing loads, error flagged
		v = {~e[15], 15'h0};
		go(flash_cfg_pkg::OP_SINGLE_WRITE, v, flash_cfg_pkg::CMD_CFG_SETUP, q);
		chk("mode", 16'(flash_cfg_pkg::MODE_STATUS), 16'(read_mode));
		go(flash_cfg_pkg::OP_SINGLE_WRITE, v, 16'h00d0, q);
		chk("seq_err", 16'h0001, 16'(cmd_seq_error));
		chk("sync", 16'(!e[15]), 16'(sync_mode));
		rd(16'h0000, q);
		chk("status", 16'h00b0, q);
		cmd(flash_cfg_pkg::CMD_CLEAR_STATUS);
		chk("seq_err", 16'h0000, 16'(cmd_seq_error));
		// offset 05h outside id mode must not show the read config
		cmd(flash_cfg_pkg::CMD_READ_CFI);
		rd(16'h0005, q);
		chk("cfi", flash_cfg_pkg::CFI_BLANK, q);
		cmd(flash_cfg_pkg::CMD_READ_STATUS);
		rd(16'h0005, q);
		chk("status", flash_cfg_pkg::STATUS_READY, q);
		// address wiring offset: value 3 shifted by one reaches offset 6
		apb(1'b1, flash_cfg_pkg::REG_SHIFT, 32'h1, r);
		cmd(flash_cfg_pkg::CMD_READ_ID);
		rd(16'h0003, q);
		chk("shift", 16'h0006, q);
		apb(1'b0, flash_cfg_pkg::REG_VALUE, 32'h0, r);
		chk("value", 16'h0003, r[15:0]);
		apb(1'b0, 8'h14, 32'h0, r);
		chk("unmapped_err", 16'h0001, 16'(err));
		chk("unmapped", 16'h0000, r[15:0]);
		// second reset in mid-run restores the defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		defaults();
		finish_test();
	end
	// watchdog sized well above the expected run of about fifteen hundred cycles
	initial begin
		#(8 * 40000);
		n_fail++;
		finish_test();
	end
endmodule
